// ---- logic/ipids_pkg.sv ----
// constants, register map and types of the drive select sequencer
package ipids_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEL_TIMEOUT_NS = 1000000;
	localparam int SEL_LIMIT_INT = SEL_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int EXCH_SETTLE_NS = 50;
	localparam int EXCH_CYC_INT = (EXCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LIMIT_W = 24;
	localparam logic [LIMIT_W-1:0] SEL_LIMIT_CYC = LIMIT_W'(SEL_LIMIT_INT);
	localparam logic [LIMIT_W-1:0] EXCH_CYC = LIMIT_W'(EXCH_CYC_INT);
	localparam logic [LIMIT_W-1:0] LIMIT_ONE = 24'h000001;

	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [5:0] OFS_STAGE = 6'h00;
	localparam logic [5:0] OFS_CMD = 6'h04;
	localparam logic [5:0] OFS_POLL_REQ = 6'h08;
	localparam logic [5:0] OFS_RST_REQ = 6'h0c;
	localparam logic [5:0] OFS_END_CFG = 6'h10;
	localparam logic [5:0] OFS_SEL_LIMIT = 6'h14;
	localparam logic [5:0] OFS_STATUS = 6'h18;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h1c;
	localparam logic [5:0] OFS_IRQ_MASK = 6'h20;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int STAGE_PRIO_BIT = 3;
	localparam int CMD_SELECT_BIT = 0;
	localparam int CMD_DESELECT_BIT = 1;
	localparam int CMD_POLL_BIT = 2;
	localparam int CMD_RESET_BIT = 3;
	localparam int CMD_ENDST_BIT = 4;
	localparam int END_PARITY_BIT = 0;
	localparam int END_GOOD_BIT = 1;
	localparam int STATUS_ERR_BIT = 3;
	localparam int STATUS_BUSB_LSB = 8;
	localparam int EV_SELECTED = 0;
	localparam int EV_BUSY = 1;
	localparam int EV_TIMEOUT = 2;
	localparam int EV_EXCH = 3;
	localparam int EV_W = 4;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;

	// ----------------------------------------
	// bus A byte fields
	// ----------------------------------------
	localparam logic BUSA_SEL_MARK = 1'b0;
	localparam logic BUSA_POLL_MARK = 1'b0;
	localparam logic BUSA_RESET_MARK = 1'b1;
	localparam logic [2:0] BUSA_SEL_PAD = 3'h0;
	localparam logic [5:0] BUSA_END_PAD = 6'h00;
	localparam logic [7:0] BUS_B_NONE = 8'h00;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_SELECT = 3'b010,
		ST_SLV_ACK = 3'b011,
		ST_DESEL = 3'b100,
		ST_EXCH = 3'b101
	} ipids_state_t;

endpackage

// ---- logic/ipids_tmr_if.sv ----
// timer hand-off between the sequencer and its selection timer
`timescale 1ns/1ps
interface ipids_tmr_if;
	logic start;
	logic run;
	logic [ipids_pkg::LIMIT_W-1:0] limit;
	logic expired;

	modport ctl (output start, output run, output limit, input expired);
	modport tmr (input start, input run, input limit, output expired);
endinterface

// ---- logic/ipids_timer.sv ----
// cycle timer for the selection limit and exchange settle time
`timescale 1ns/1ps
module ipids_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	ipids_tmr_if.tmr tmr
);
	logic [ipids_pkg::LIMIT_W-1:0] cnt_q;
	logic expired_q;

	assign tmr.expired = expired_q;

	// counts limit cycles of run after start, then holds expired
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_q <= '0;
			expired_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (tmr.start)
			begin
				cnt_q <= '0;
				expired_q <= 1'b0;
			end
			else if (tmr.run && !expired_q)
			begin
				if (cnt_q + ipids_pkg::LIMIT_ONE >= tmr.limit)
					expired_q <= 1'b1;
				else
					cnt_q <= cnt_q + ipids_pkg::LIMIT_ONE;
			end
		end
	end
endmodule

// ---- logic/ipids_seq.sv ----
// drive select sequencer with avalon-mm register slave
//
// Summary of operation
// - from idle, a select loads bus A from the staging register first
// - select byte: 0, drive address in 6..4, zeros, priority flag in bit 0
// - after the address, select out rises, entering the select state
// - on a busy answer select out drops and deselect is entered
// - no slave in within the limit drops select out, back to idle
// - poll: bus A bit 7 zero, bits 6..0 report requests, bus B per drive
// - drive reset: bus A bit 7 one, address 6..4, reset flags 3..0
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module ipids_seq #(
	parameter logic [ipids_pkg::LIMIT_W-1:0] SEL_LIMIT_CYC = ipids_pkg::SEL_LIMIT_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	output logic select_out_o,
	output logic [7:0] bus_a_o,
	input wire logic slave_in_i,
	input wire logic [7:0] bus_b_i
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	ipids_tmr_if tmr_if ();
	ipids_pkg::ipids_state_t state_q;
	ipids_pkg::ipids_state_t ret_q;
	logic waitreq_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	logic irq_q;
	logic select_q;
	logic [7:0] bus_a_q;
	logic [2:0] addr_q;
	logic prio_q;
	logic [6:0] poll_req_q;
	logic [3:0] rst_req_q;
	logic [1:0] end_cfg_q;
	logic [ipids_pkg::LIMIT_W-1:0] sel_limit_q;
	logic [ipids_pkg::EV_W-1:0] irq_stat_q;
	logic [ipids_pkg::EV_W-1:0] irq_mask_q;
	logic [ipids_pkg::EV_W-1:0] ev;
	logic err_q;
	logic [7:0] busb_cap_q;
	logic [8:0] sync1_q;
	logic [8:0] sync2_q;
	logic slave_s;
	logic [7:0] bus_b_s;
	logic wr_go;
	logic rd_go;
	logic cmd_wr;
	logic go_select;
	logic go_deselect;
	logic go_poll;
	logic go_reset;
	logic go_endst;
	logic go_exch;
	logic sel_norm;
	logic sel_busy;
	logic sel_tmo;
	logic exch_end;

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = waitreq_q;
	assign irq_o = irq_q;
	assign select_out_o = select_q;
	assign bus_a_o = bus_a_q;

	// ----------------------------------------
	// bus A byte builders
	// ----------------------------------------
	function automatic logic [7:0] sel_byte(input logic [2:0] a, input logic p);
		sel_byte = {ipids_pkg::BUSA_SEL_MARK, a, ipids_pkg::BUSA_SEL_PAD, p};
	endfunction

	function automatic logic [7:0] reset_byte(input logic [2:0] a, input logic [3:0] f);
		reset_byte = {ipids_pkg::BUSA_RESET_MARK, a, f};
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else if (ce_i)
		begin
			sync1_q <= {slave_in_i, bus_b_i};
			sync2_q <= sync1_q;
		end
	end

	assign slave_s = sync2_q[8];
	assign bus_b_s = sync2_q[7:0];

	// ----------------------------------------
	// avalon slave: one wait state per access
	// ----------------------------------------
	assign wr_go = avs_write_i && !waitreq_q;
	assign rd_go = avs_read_i && !waitreq_q;

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			waitreq_q <= 1'b1;
		else if (ce_i)
			waitreq_q <= !((avs_read_i || avs_write_i) && waitreq_q);
	end

	always_comb
	begin
		rd_mux = ipids_pkg::RD_ZERO;
		if (avs_address_i == ipids_pkg::OFS_STAGE)
			rd_mux = {28'h0, prio_q, addr_q};
		else if (avs_address_i == ipids_pkg::OFS_POLL_REQ)
			rd_mux = {25'h0, poll_req_q};
		else if (avs_address_i == ipids_pkg::OFS_RST_REQ)
			rd_mux = {28'h0, rst_req_q};
		else if (avs_address_i == ipids_pkg::OFS_END_CFG)
			rd_mux = {30'h0, end_cfg_q};
		else if (avs_address_i == ipids_pkg::OFS_SEL_LIMIT)
			rd_mux = {8'h0, sel_limit_q};
		else if (avs_address_i == ipids_pkg::OFS_STATUS)
			rd_mux = {16'h0, busb_cap_q, 4'h0, err_q, state_q};
		else if (avs_address_i == ipids_pkg::OFS_IRQ_STAT)
			rd_mux = {28'h0, irq_stat_q};
		else if (avs_address_i == ipids_pkg::OFS_IRQ_MASK)
			rd_mux = {28'h0, irq_mask_q};
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			rdata_q <= '0;
		else if (ce_i && avs_read_i && waitreq_q)
			rdata_q <= rd_mux;
	end

	// staging and configuration registers
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			addr_q <= '0;
			prio_q <= 1'b0;
			poll_req_q <= '0;
			rst_req_q <= '0;
			end_cfg_q <= '0;
			sel_limit_q <= SEL_LIMIT_CYC;
			irq_mask_q <= '0;
		end
		else if (ce_i && wr_go)
		begin
			if (avs_address_i == ipids_pkg::OFS_STAGE)
			begin
				addr_q <= avs_writedata_i[2:0];
				prio_q <= avs_writedata_i[ipids_pkg::STAGE_PRIO_BIT];
			end
			else if (avs_address_i == ipids_pkg::OFS_POLL_REQ)
				poll_req_q <= avs_writedata_i[6:0];
			else if (avs_address_i == ipids_pkg::OFS_RST_REQ)
				rst_req_q <= avs_writedata_i[3:0];
			else if (avs_address_i == ipids_pkg::OFS_END_CFG)
				end_cfg_q <= avs_writedata_i[1:0];
			else if (avs_address_i == ipids_pkg::OFS_SEL_LIMIT)
				sel_limit_q <= avs_writedata_i[ipids_pkg::LIMIT_W-1:0];
			else if (avs_address_i == ipids_pkg::OFS_IRQ_MASK)
				irq_mask_q <= avs_writedata_i[ipids_pkg::EV_W-1:0];
		end
	end

	// ----------------------------------------
	// command decode and answer classification
	// ----------------------------------------
	assign cmd_wr = wr_go && (avs_address_i == ipids_pkg::OFS_CMD);
	assign go_select = cmd_wr && avs_writedata_i[ipids_pkg::CMD_SELECT_BIT]
		&& (state_q == ipids_pkg::ST_IDLE);
	assign go_deselect = cmd_wr && avs_writedata_i[ipids_pkg::CMD_DESELECT_BIT]
		&& (state_q == ipids_pkg::ST_SLV_ACK);
	assign go_poll = cmd_wr && avs_writedata_i[ipids_pkg::CMD_POLL_BIT]
		&& (state_q == ipids_pkg::ST_IDLE) && !go_select;
	assign go_reset = cmd_wr && avs_writedata_i[ipids_pkg::CMD_RESET_BIT]
		&& (state_q == ipids_pkg::ST_IDLE) && !go_select && !go_poll;
	assign go_endst = cmd_wr && avs_writedata_i[ipids_pkg::CMD_ENDST_BIT]
		&& (state_q == ipids_pkg::ST_SLV_ACK) && !go_deselect;
	assign go_exch = go_poll || go_reset || go_endst;

	assign sel_norm = (state_q == ipids_pkg::ST_SELECT) && slave_s
		&& (bus_b_s != ipids_pkg::BUS_B_NONE);
	assign sel_busy = (state_q == ipids_pkg::ST_SELECT) && slave_s
		&& (bus_b_s == ipids_pkg::BUS_B_NONE);
	assign sel_tmo = (state_q == ipids_pkg::ST_SELECT) && !slave_s && tmr_if.expired;
	assign exch_end = (state_q == ipids_pkg::ST_EXCH) && tmr_if.expired;

	assign tmr_if.start = (state_q == ipids_pkg::ST_ADDR) || go_exch;
	assign tmr_if.run = (state_q == ipids_pkg::ST_SELECT) || (state_q == ipids_pkg::ST_EXCH);
	assign tmr_if.limit = (state_q == ipids_pkg::ST_EXCH) ? ipids_pkg::EXCH_CYC : sel_limit_q;

	ipids_timer u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.tmr(tmr_if.tmr)
	);

	// ----------------------------------------
	// interface sequencer
	// ----------------------------------------
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_q <= ipids_pkg::ST_IDLE;
			ret_q <= ipids_pkg::ST_IDLE;
			select_q <= 1'b0;
			bus_a_q <= '0;
			err_q <= 1'b0;
			busb_cap_q <= '0;
		end
		else if (ce_i)
		begin
			case (state_q)
				ipids_pkg::ST_IDLE:
				begin
					if (go_select)
					begin
						bus_a_q <= sel_byte(addr_q, prio_q);
						err_q <= 1'b0;
						state_q <= ipids_pkg::ST_ADDR;
					end
					else if (go_poll)
					begin
						bus_a_q <= {ipids_pkg::BUSA_POLL_MARK, poll_req_q};
						ret_q <= ipids_pkg::ST_IDLE;
						state_q <= ipids_pkg::ST_EXCH;
					end
					else if (go_reset)
					begin
						bus_a_q <= reset_byte(addr_q, rst_req_q);
						ret_q <= ipids_pkg::ST_IDLE;
						state_q <= ipids_pkg::ST_EXCH;
					end
				end
				ipids_pkg::ST_ADDR:
				begin
					select_q <= 1'b1;
					state_q <= ipids_pkg::ST_SELECT;
				end
				ipids_pkg::ST_SELECT:
				begin
					if (sel_norm)
					begin
						busb_cap_q <= bus_b_s;
						state_q <= ipids_pkg::ST_SLV_ACK;
					end
					else if (sel_busy)
					begin
						select_q <= 1'b0;
						busb_cap_q <= bus_b_s;
						state_q <= ipids_pkg::ST_DESEL;
					end
					else if (sel_tmo)
					begin
						select_q <= 1'b0;
						err_q <= 1'b1;
						state_q <= ipids_pkg::ST_IDLE;
					end
				end
				ipids_pkg::ST_SLV_ACK:
				begin
					if (go_deselect)
					begin
						select_q <= 1'b0;
						state_q <= ipids_pkg::ST_DESEL;
					end
					else if (go_endst)
					begin
						bus_a_q <= {end_cfg_q[ipids_pkg::END_GOOD_BIT],
							end_cfg_q[ipids_pkg::END_PARITY_BIT], ipids_pkg::BUSA_END_PAD};
						ret_q <= ipids_pkg::ST_SLV_ACK;
						state_q <= ipids_pkg::ST_EXCH;
					end
				end
				ipids_pkg::ST_DESEL:
				begin
					if (!slave_s)
						state_q <= ipids_pkg::ST_IDLE;
				end
				ipids_pkg::ST_EXCH:
				begin
					if (exch_end)
					begin
						busb_cap_q <= bus_b_s;
						state_q <= ret_q;
					end
				end
				default:
				begin
					select_q <= 1'b0;
					state_q <= ipids_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// interrupts: sticky status, read clears, set wins
	// ----------------------------------------
	always_comb
	begin
		ev = '0;
		ev[ipids_pkg::EV_SELECTED] = sel_norm;
		ev[ipids_pkg::EV_BUSY] = sel_busy;
		ev[ipids_pkg::EV_TIMEOUT] = sel_tmo;
		ev[ipids_pkg::EV_EXCH] = exch_end;
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_stat_q <= '0;
		else if (ce_i)
		begin
			// clear only what the read reported; later events survive
			if (rd_go && (avs_address_i == ipids_pkg::OFS_IRQ_STAT))
				irq_stat_q <= (irq_stat_q & ~rdata_q[ipids_pkg::EV_W-1:0]) | ev;
			else
				irq_stat_q <= irq_stat_q | ev;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
			irq_q <= 1'b0;
		else if (ce_i)
			irq_q <= |(irq_stat_q & irq_mask_q);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_sel_byte_fmt: assert property (state_q == ipids_pkg::ST_SELECT |->
		bus_a_o == {1'b0, addr_q, 3'h0, prio_q})
		else $error("select byte on bus A malformed");
	chk_sel_rise: assert property (ce_i && go_select ##1 ce_i |=>
		select_out_o && bus_a_o[7] == 1'b0 && state_q == ipids_pkg::ST_SELECT)
		else $error("select out did not rise after the address");
	chk_busy_drop: assert property (ce_i && sel_busy |=>
		!select_out_o && state_q == ipids_pkg::ST_DESEL)
		else $error("busy answer did not drop select out");
	chk_desel_idle: assert property (ce_i && state_q == ipids_pkg::ST_DESEL && !slave_s |=>
		state_q == ipids_pkg::ST_IDLE)
		else $error("deselect did not return to idle");
	chk_tmo_drop: assert property (ce_i && sel_tmo |=>
		!select_out_o && state_q == ipids_pkg::ST_IDLE && err_q)
		else $error("selection timeout did not drop select out");
	chk_tmo_flag: assert property (ce_i && sel_tmo && irq_mask_q[ipids_pkg::EV_TIMEOUT]
		##1 ce_i |=> irq_o)
		else $error("timeout did not raise the interrupt");
	chk_poll_byte: assert property (state_q == ipids_pkg::ST_EXCH &&
		ret_q == ipids_pkg::ST_IDLE && !bus_a_o[7] |-> bus_a_o[6:0] == poll_req_q)
		else $error("poll byte on bus A malformed");
	chk_reset_byte: assert property (state_q == ipids_pkg::ST_EXCH &&
		ret_q == ipids_pkg::ST_IDLE && bus_a_o[7] |->
		bus_a_o[6:4] == addr_q && bus_a_o[3:0] == rst_req_q)
		else $error("drive reset byte on bus A malformed");
	chk_end_byte: assert property (state_q == ipids_pkg::ST_EXCH &&
		ret_q == ipids_pkg::ST_SLV_ACK |-> bus_a_o[5:0] == 6'h00)
		else $error("ending status byte has stray bits");
	chk_bus_ack: assert property ((avs_read_i || avs_write_i) && waitreq_q && ce_i |=>
		!avs_waitrequest_o)
		else $error("bus access not answered in one wait state");
endmodule

// ---- verification/ipids_drive_model.sv ----
// behavioural model of one disk drive on the select interface
`timescale 1ns/1ps
module ipids_drive_model #(
	parameter logic [2:0] ADDR = 3'h5
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic select_i,
	input wire logic [7:0] bus_a_i,
	input wire logic busy_i,
	input wire logic [3:0] delay_i,
	input wire logic [7:0] poll_resp_i,
	output logic slave_o,
	output logic [7:0] bus_b_o
);
	logic [3:0] wait_q;
	logic toggle_q;
	logic hit;

	// ----------------------------------------
	// select answer
	// ----------------------------------------
	assign hit = select_i && !bus_a_i[7] && (bus_a_i[6:4] == ADDR);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			slave_o <= 1'b0;
			wait_q <= 4'h0;
			toggle_q <= 1'b0;
		end
		else
		begin
			toggle_q <= !toggle_q;
			if (!select_i)
			begin
				slave_o <= 1'b0;
				wait_q <= 4'h0;
			end
			else if (hit && !slave_o)
			begin
				if (wait_q >= delay_i)
					slave_o <= 1'b1;
				else
					wait_q <= wait_q + 4'h1;
			end
		end
	end

	// busy drive leaves bus B empty; an unanswered bus B never holds still
	always_comb
	begin
		if (slave_o)
			bus_b_o = busy_i ? 8'h00 : (8'h01 << ADDR);
		else if (select_i)
			bus_b_o = toggle_q ? 8'h5a : 8'ha5;
		else
			bus_b_o = poll_resp_i;
	end
endmodule

// ---- verification/ipi2_drive_select_sequencer_tb.sv ----
// self-checking bench of the drive select sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) \
	begin compares++; if ((g) !== (e)) begin bad_count++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module ipi2_drive_select_sequencer_tb;
	localparam logic [23:0] LIM = 24'h000014;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [5:0] address = 6'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wait_req;
	logic irq;
	logic sel;
	logic slave;
	logic [7:0] bus_a;
	logic [7:0] bus_b;
	logic busy = 1'b0;
	logic [3:0] delay = 4'h0;
	logic ce = 1'b1;
	logic wq_s = 1'b1;
	logic [31:0] rd_s = 32'h0;
	logic [31:0] q;
	int n;
	int bad_count = 0;
	int compares = 0;
	int cyc = 0;

	ipids_seq #(.SEL_LIMIT_CYC(LIM)) DUT (.clk_i(clock_i), .rst_i(rst_i), .ce_i(ce),
		.avs_address_i(address), .avs_read_i(rd_en), .avs_write_i(wr_en),
		.avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
		.irq_o(irq), .select_out_o(sel), .bus_a_o(bus_a), .slave_in_i(slave), .bus_b_i(bus_b));
	ipids_drive_model #(.ADDR(3'h5)) drive (.clock_i(clock_i), .rst_i(rst_i), .select_i(sel),
		.bus_a_i(bus_a), .busy_i(busy), .delay_i(delay), .poll_resp_i(8'h24),
		.slave_o(slave), .bus_b_o(bus_b));

	// ----------------------------------------
	// clock, sampling, hang guard
	// ----------------------------------------
	initial
	begin
		forever #5 clock_i = ~clock_i;
	end

	// values as they stand just before the next rising edge
	always @(negedge clock_i)
	begin
		wq_s = wait_req;
		rd_s = rdata;
	end

	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			bad_count++;
			give_verdict;
		end
	end

	task automatic give_verdict;
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// bus and wait helpers
	// ----------------------------------------
	task automatic bus_op(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clock_i);
		address <= a;
		wr_en <= w;
		rd_en <= !w;
		wdata <= d;
		// ends when waitrequest is seen low; no limit of its own, so only the bench timeout ends a hung wait
		do
		begin
			@(posedge clock_i);
		end
		while (wq_s !== 1'b0);
		q = rd_s;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		`CHK("bus_answer", 1'b0, wq_s)
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus_op(1'b1, a, d);
	endtask

	task automatic rd(input logic [5:0] a);
		bus_op(1'b0, a, 32'h0);
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge clock_i);
		#1;
	endtask

	task automatic wait_state(input logic [2:0] s);
		int k;
		k = 0;
		do begin rd(ipids_pkg::OFS_STATUS); k++; end while (q[2:0] !== s && k < 100);
		`CHK("state", s, q[2:0])
	endtask

	task automatic wait_sel(input logic v);
		n = 0;
		while (sel !== v && n < 100)
		begin
			tick(1);
			n++;
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		`CHK("sel_rst", 1'b0, sel)
		`CHK("busa_rst", 8'h00, bus_a)
		rd(ipids_pkg::OFS_SEL_LIMIT);
		`CHK("limit_rst", 32'h14, q)
		rd(6'h3c);
		`CHK("unmapped", 32'h0, q)
	endtask

	task automatic t_normal;
		wr(ipids_pkg::OFS_IRQ_MASK, 32'h1);
		wr(ipids_pkg::OFS_STAGE, 32'hd);
		wr(ipids_pkg::OFS_CMD, 32'h1);
		tick(0);
		`CHK("sel_busa", 8'h51, bus_a)
		`CHK("sel_early", 1'b0, sel)
		tick(1);
		`CHK("sel_rise", 1'b1, sel)
		wait_state(3'h3);
		rd(ipids_pkg::OFS_STATUS);
		`CHK("busb_cap", 8'h20, q[15:8])
		`CHK("irq_on", 1'b1, irq)
		rd(ipids_pkg::OFS_IRQ_STAT);
		`CHK("ev_sel", 32'h1, q)
		tick(2);
		`CHK("irq_off", 1'b0, irq)
		wr(ipids_pkg::OFS_END_CFG, 32'h1);
		wr(ipids_pkg::OFS_CMD, 32'h10);
		tick(1);
		`CHK("end_busa", 8'h40, bus_a)
		wait_state(3'h3);
		rd(ipids_pkg::OFS_IRQ_STAT);
		`CHK("ev_exch", 32'h8, q)
		wr(ipids_pkg::OFS_CMD, 32'h2);
		wait_state(3'h0);
		`CHK("desel", 1'b0, sel)
	endtask

	task automatic t_busy;
		busy <= 1'b1;
		delay <= 4'h9;
		wr(ipids_pkg::OFS_IRQ_MASK, 32'h0);
		wr(ipids_pkg::OFS_CMD, 32'h1);
		wait_sel(1'b1);
		wait_sel(1'b0);
		`CHK("busy_drop", 1'b1, n < 100)
		wait_state(3'h0);
		rd(ipids_pkg::OFS_IRQ_STAT);
		`CHK("ev_busy", 32'h2, q)
		`CHK("irq_masked", 1'b0, irq)
		busy <= 1'b0;
	endtask

	task automatic t_timeout;
		int lim;
		wr(ipids_pkg::OFS_STAGE, 32'h6);
		for (int i = 0; i < 2; i++)
		begin
			lim = i ? 8 : 20;
			if (i)
			begin
				wr(ipids_pkg::OFS_SEL_LIMIT, 32'h8);
				wr(ipids_pkg::OFS_IRQ_MASK, 32'h4);
			end
			wr(ipids_pkg::OFS_CMD, 32'h1);
			wait_sel(1'b1);
			// clock enable low must freeze the selection timer
			if (i)
			begin
				@(posedge clock_i);
				ce <= 1'b0;
				repeat (20) @(posedge clock_i);
				`CHK("ce_hold", 1'b1, sel)
				ce <= 1'b1;
			end
			wait_sel(1'b0);
			`CHK("tmo_len", 1'b1, n >= lim - 1 && n <= lim + 2)
			rd(ipids_pkg::OFS_STATUS);
			`CHK("tmo_err", 4'h8, q[3:0])
			`CHK("tmo_irq", i[0], irq)
			rd(ipids_pkg::OFS_IRQ_STAT);
			`CHK("tmo_ev", 32'h4, q)
		end
	endtask

	task automatic t_poll_reset;
		wr(ipids_pkg::OFS_POLL_REQ, 32'hff);
		wr(ipids_pkg::OFS_CMD, 32'h4);
		tick(1);
		`CHK("poll_busa", 8'h7f, bus_a)
		wait_state(3'h0);
		rd(ipids_pkg::OFS_STATUS);
		`CHK("poll_busb", 8'h24, q[15:8])
		wr(ipids_pkg::OFS_STAGE, 32'h2);
		wr(ipids_pkg::OFS_RST_REQ, 32'h9);
		wr(ipids_pkg::OFS_CMD, 32'h8);
		tick(1);
		`CHK("rst_busa", 8'ha9, bus_a)
		`CHK("rst_sel", 1'b0, sel)
		wait_state(3'h0);
	endtask

	initial
	begin
		repeat (20) @(posedge clock_i);
		rst_i <= 1'b0;
		tick(1);
		t_reset;
		t_normal;
		t_busy;
		t_timeout;
		t_poll_reset;
		give_verdict;
	end
endmodule
